// File: design/sep_slave.sv
// Purpose: two-wire slave port of a 256-byte memory with page write
// Assumes: scl_in, sda_in and straps are asynchronous pins
// Notes: sda is open drain; sda_oe_n low pulls the line to sda_o (0)
// Functional notes
// - Program cycle ends within ten milliseconds
// - While programming, bus ignored, data released
// - Three straps allow eight devices per bus
// - Data line only pulled low or released
// - Write-protect high refuses every memory change
// - Data change with clock high is START/STOP
// - START is data falling, clock high
// - STOP is data rising, clock high
// - Memory address prefix must be 1010
// - Next three bits must equal strap levels
// - Address LSB one reads, zero writes
// - Matching address acknowledged, else stay silent
// - Receiver holds data low on ninth clock
// - Write mode acknowledges every received byte unless the FIFO is full
// - Read mode continues only on master acknowledge
// - Byte write ends with STOP, then programming
// - Page write buffers sixteen bytes, one cycle
// - Only low address bits increment per written byte
// - Over sixteen bytes wrap and overwrite buffer
// - Protect register writable once, prefix 0110
// - Address not acknowledged while still programming
`timescale 1ns/1ps
`default_nettype none
module sep_slave #(
	parameter int PROG_CYCLES = sep_pkg::PROG_CYCLES,
	parameter int FIFO_DEPTH = sep_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Serial bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_o,
	output logic sda_oe_n,
	// Straps
	input wire logic [sep_pkg::SEL_W-1:0] device_select_inputs,
	input wire logic write_protect_in,
	// Status
	output logic prog_busy,
	output logic prot_locked
);
	import sep_pkg::*;

	localparam int CW = $clog2(PROG_CYCLES + 1);

	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_s3;
		logic sda_s1;
		logic sda_s2;
		logic sda_s3;
		logic [SEL_W-1:0] sel_s1;
		logic [SEL_W-1:0] sel_s2;
		logic wp_s1;
		logic wp_s2;
		sep_state_t state;
		sep_kind_t kind;
		logic [3:0] bitcnt;
		logic [DATA_W-1:0] shreg;
		logic rd_dir;
		logic prot_sel;
		logic mst_ack;
		logic data_seen;
		logic [ADDR_W-1:0] ptr;
		logic [PAGE_W-1:0] page;
		logic [PAGE_SIZE-1:0][DATA_W-1:0] pbuf;
		logic [PAGE_SIZE-1:0] pvalid;
		logic wr_pend;
		logic prot_pend;
		logic prot_lock;
		logic busy;
		logic [CW-1:0] timer;
		logic [MEM_SIZE-1:0][DATA_W-1:0] mem;
		logic sda_oe_n;
		logic sda_o;
	} sep_core_t;

	sep_core_t state_reg;
	sep_core_t state_next;

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic slave_end;
	logic mem_hit;
	logic prot_hit;
	logic ack;
	logic load_tx;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [FIFO_W-1:0] fifo_in_data;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [FIFO_W-1:0] fifo_out_data;

	// Address in the soft-protected half once the lock is set
	function automatic logic soft_locked(input logic [ADDR_W-1:0] a, input logic lock);
		soft_locked = lock && (a <= PROT_TOP_ADDR);
	endfunction : soft_locked

	// Bus events, seen only on the second and third sync stages
	assign scl_rise = state_reg.scl_s2 && !state_reg.scl_s3;
	assign scl_fall = !state_reg.scl_s2 && state_reg.scl_s3;
	assign start_det = state_reg.scl_s2 && state_reg.scl_s3 && state_reg.sda_s3 && !state_reg.sda_s2;
	assign stop_det = state_reg.scl_s2 && state_reg.scl_s3 && !state_reg.sda_s3 && state_reg.sda_s2;
	assign slave_end = (state_reg.state == ST_RX) && (state_reg.kind == K_SLAVE)
		&& (state_reg.bitcnt == BYTE_BITS) && scl_fall && !start_det && !stop_det;

	// Address compare against prefix and straps
	assign mem_hit = sep_addr_match(state_reg.shreg, MEM_PREFIX, state_reg.sel_s2);
	assign prot_hit = sep_addr_match(state_reg.shreg, PROT_PREFIX, state_reg.sel_s2)
		&& (state_reg.shreg[DIR_BIT] != DIR_READ);

	// Page buffer drain stalls during the program cycle, so the FIFO can fill
	assign fifo_out_ready = !state_reg.busy;

	sep_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(core_clk),
		.rst(rst),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// Next-state logic of the whole port
	always_comb
	begin
		state_next = state_reg;
		ack = 1'h0;
		load_tx = 1'h0;
		fifo_in_valid = 1'h0;
		fifo_in_data = '0;
		state_next.scl_s1 = scl_in;
		state_next.scl_s2 = state_reg.scl_s1;
		state_next.scl_s3 = state_reg.scl_s2;
		state_next.sda_s1 = sda_in;
		state_next.sda_s2 = state_reg.sda_s1;
		state_next.sda_s3 = state_reg.sda_s2;
		state_next.sel_s1 = device_select_inputs;
		state_next.sel_s2 = state_reg.sel_s1;
		state_next.wp_s1 = write_protect_in;
		state_next.wp_s2 = state_reg.wp_s1;
		state_next.sda_o = 1'h0;

		// Drain: later bytes for the same slot overwrite earlier ones
		if (fifo_out_valid && fifo_out_ready)
		begin
			state_next.pbuf[fifo_out_data[FIFO_W-1 -: PAGE_W]] = fifo_out_data[DATA_W-1:0];
			state_next.pvalid[fifo_out_data[FIFO_W-1 -: PAGE_W]] = 1'h1;
		end

		// Self-timed program cycle, committed when the timer expires
		if (state_reg.busy)
		begin
			if (state_reg.timer == '0)
			begin
				state_next.busy = 1'h0;
				for (int i = 0; i < PAGE_SIZE; i++)
				begin
					if (state_reg.pvalid[i] && !state_reg.wp_s2
						&& !soft_locked({state_reg.page, PAGE_W'(i)}, state_reg.prot_lock))
						state_next.mem[{state_reg.page, PAGE_W'(i)}] = state_reg.pbuf[i];
				end
				if (state_reg.prot_pend && !state_reg.wp_s2)
					state_next.prot_lock = 1'h1;
				state_next.pvalid = '0;
				state_next.prot_pend = 1'h0;
			end
			else
				state_next.timer = state_reg.timer - 1'h1;
		end
		else if (state_reg.wr_pend && !fifo_out_valid)
		begin
			// Start only once every buffered byte has reached the page
			state_next.busy = 1'h1;
			state_next.timer = CW'(PROG_CYCLES - 1);
			state_next.wr_pend = 1'h0;
		end

		// Bus framing: START and STOP override any transfer in flight
		if (start_det)
		begin
			state_next.state = ST_RX;
			state_next.kind = K_SLAVE;
			state_next.bitcnt = '0;
			state_next.sda_oe_n = 1'h1;
		end
		else if (stop_det)
		begin
			state_next.state = ST_IDLE;
			state_next.sda_oe_n = 1'h1;
			if (state_reg.data_seen)
				state_next.wr_pend = 1'h1;
			state_next.data_seen = 1'h0;
		end
		else
		begin
			unique case (state_reg.state)
				ST_IDLE:
				begin
					state_next.sda_oe_n = 1'h1;
				end
				ST_RX:
				begin
					if (scl_rise)
					begin
						state_next.shreg = {state_reg.shreg[DATA_W-2:0], state_reg.sda_s2};
						state_next.bitcnt = state_reg.bitcnt + 1'h1;
					end
					else if (scl_fall && state_reg.bitcnt == BYTE_BITS)
					begin
						unique case (state_reg.kind)
							K_SLAVE:
							begin
								// Busy: even a matching address goes unanswered
								if (!state_reg.busy && mem_hit)
								begin
									ack = 1'h1;
									state_next.rd_dir = (state_reg.shreg[DIR_BIT] == DIR_READ);
									state_next.prot_sel = 1'h0;
								end
								else if (!state_reg.busy && prot_hit && !state_reg.prot_lock)
								begin
									ack = 1'h1;
									state_next.rd_dir = 1'h0;
									state_next.prot_sel = 1'h1;
								end
							end
							K_WADDR:
							begin
								ack = 1'h1;
								if (!state_reg.prot_sel)
									state_next.ptr = state_reg.shreg;
							end
							K_DATA:
							begin
								if (state_reg.prot_sel)
								begin
									ack = 1'h1;
									state_next.prot_pend = 1'h1;
									state_next.data_seen = 1'h1;
								end
								else if (fifo_in_ready)
								begin
									// A full FIFO turns into a withheld acknowledge
									ack = 1'h1;
									fifo_in_valid = 1'h1;
									fifo_in_data = {state_reg.ptr[PAGE_W-1:0], state_reg.shreg};
									state_next.page = state_reg.ptr[ADDR_W-1:PAGE_W];
									state_next.ptr = {state_reg.ptr[ADDR_W-1:PAGE_W],
										state_reg.ptr[PAGE_W-1:0] + 1'h1};
									state_next.data_seen = 1'h1;
								end
							end
							default:
							begin
								ack = 1'h0;
							end
						endcase
						state_next.kind = (state_reg.kind == K_SLAVE) ? K_WADDR : K_DATA;
						if (ack)
						begin
							state_next.state = ST_ACK;
							state_next.sda_oe_n = 1'h0;
						end
						else
							state_next.state = ST_IDLE;
					end
				end
				ST_ACK:
				begin
					// Hold the line low through the whole ninth clock
					if (scl_fall)
					begin
						state_next.sda_oe_n = 1'h1;
						state_next.bitcnt = '0;
						if (state_reg.rd_dir)
							load_tx = 1'h1;
						else
							state_next.state = ST_RX;
					end
				end
				ST_TX:
				begin
					if (scl_rise)
						state_next.bitcnt = state_reg.bitcnt + 1'h1;
					else if (scl_fall)
					begin
						if (state_reg.bitcnt == BYTE_BITS)
						begin
							state_next.sda_oe_n = 1'h1;
							state_next.state = ST_TXACK;
						end
						else
						begin
							state_next.sda_oe_n = state_reg.shreg[DATA_W-2];
							state_next.shreg = {state_reg.shreg[DATA_W-2:0], 1'h0};
						end
					end
				end
				ST_TXACK:
				begin
					if (scl_rise)
						state_next.mst_ack = !state_reg.sda_s2;
					else if (scl_fall)
					begin
						state_next.bitcnt = '0;
						if (state_reg.mst_ack)
							load_tx = 1'h1;
						else
							state_next.state = ST_IDLE;
					end
				end
				default:
				begin
					state_next.state = ST_IDLE;
				end
			endcase
		end

		// Read byte load: first bit driven as soon as the clock is low
		if (load_tx)
		begin
			state_next.state = ST_TX;
			state_next.shreg = state_reg.mem[state_reg.ptr];
			state_next.sda_oe_n = state_reg.mem[state_reg.ptr][DATA_W-1];
			state_next.ptr = state_reg.ptr + 1'h1;
		end
	end

	// Array resets to the erased value; only control state matters here
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_reg <= '0;
			state_reg.sda_oe_n <= 1'h1;
			// Sync stages start at the idle high level, so no false edge follows reset
			state_reg.scl_s1 <= 1'h1;
			state_reg.scl_s2 <= 1'h1;
			state_reg.scl_s3 <= 1'h1;
			state_reg.sda_s1 <= 1'h1;
			state_reg.sda_s2 <= 1'h1;
			state_reg.sda_s3 <= 1'h1;
			state_reg.mem <= {MEM_SIZE{ERASED_BYTE}};
		end
		else
			state_reg <= state_next;
	end

	// Pins and status straight from the state register
	assign sda_o = state_reg.sda_o;
	assign sda_oe_n = state_reg.sda_oe_n;
	assign prog_busy = state_reg.busy;
	assign prot_locked = state_reg.prot_lock;

	// Helper: length of the current program cycle
	int busy_len;
	always_ff @(posedge core_clk)
	begin
		if (rst || !state_reg.busy)
			busy_len <= 1;
		else
			busy_len <= busy_len + 1;
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	property p_prog_len;
		$fell(state_reg.busy) |-> ($past(busy_len) == PROG_CYCLES);
	endproperty
	a_prog_len: assert property (p_prog_len) else $error("program cycle length wrong");

	property p_busy_release;
		state_reg.busy |-> state_reg.sda_oe_n;
	endproperty
	a_busy_release: assert property (p_busy_release) else $error("data driven while busy");

	property p_od_low;
		!sda_oe_n |-> (sda_o == 1'h0);
	endproperty
	a_od_low: assert property (p_od_low) else $error("data line driven high");

	property p_idle_quiet;
		(state_reg.state == ST_IDLE) |-> sda_oe_n;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("driving while idle");

	property p_addr_nack;
		slave_end && !mem_hit && !prot_hit |=> sda_oe_n [*2];
	endproperty
	a_addr_nack: assert property (p_addr_nack) else $error("foreign address acknowledged");

	property p_addr_ack;
		slave_end && mem_hit && !state_reg.busy |=> !sda_oe_n && (state_reg.state == ST_ACK);
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

	property p_poll_nack;
		slave_end && state_reg.busy |=> sda_oe_n && (state_reg.state == ST_IDLE);
	endproperty
	a_poll_nack: assert property (p_poll_nack) else $error("acknowledged while busy");

	property p_page_inc;
		fifo_in_valid |=> (state_reg.ptr[ADDR_W-1:PAGE_W] == $past(state_reg.ptr[ADDR_W-1:PAGE_W]))
			&& (state_reg.ptr[PAGE_W-1:0] == PAGE_W'($past(state_reg.ptr[PAGE_W-1:0]) + 1'h1));
	endproperty
	a_page_inc: assert property (p_page_inc) else $error("page pointer step wrong");

	property p_wp_hold;
		state_reg.busy && (state_reg.timer == '0) && state_reg.wp_s2 |=> $stable(state_reg.mem);
	endproperty
	a_wp_hold: assert property (p_wp_hold) else $error("array changed under write protect");

	property p_stop_prog;
		stop_det && !start_det && state_reg.data_seen |=> state_reg.wr_pend ##[1:40] state_reg.busy;
	endproperty
	a_stop_prog: assert property (p_stop_prog) else $error("no program cycle after stop");

	property p_lock_nack;
		slave_end && state_reg.prot_lock && prot_hit |=> sda_oe_n;
	endproperty
	a_lock_nack: assert property (p_lock_nack) else $error("locked register acknowledged");

	c_prog: cover property ($rose(state_reg.busy));
	c_read_more: cover property ((state_reg.state == ST_TXACK) && scl_fall && state_reg.mst_ack);
	c_poll: cover property (slave_end && state_reg.busy);
	c_fifo_full: cover property (!fifo_in_ready);

endmodule : sep_slave
`default_nettype wire

// File: common/sep_pkg.sv
// Purpose: shared constants and types of the serial memory slave port
// Assumes: 50 MHz core clock, 256 x 8 array, 16-byte page
// Notes: timing counts are derived from times given in microseconds
package sep_pkg;

	// Clock and program cycle timing
	localparam int CLK_FREQ_MHZ = 50;
	localparam int PROG_TIME_TYP_US = 4000;
	localparam int PROG_TIME_MAX_US = 10000;
	localparam int PROG_CYCLES = PROG_TIME_TYP_US * CLK_FREQ_MHZ;
	localparam int PROG_CYCLES_MAX = PROG_TIME_MAX_US * CLK_FREQ_MHZ;

	// Array and page geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int PAGE_W = 4;
	localparam int SEL_W = 3;
	localparam int MEM_SIZE = 2 ** ADDR_W;
	localparam int PAGE_SIZE = 2 ** PAGE_W;
	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_W = PAGE_W + DATA_W;

	// Slave address byte layout
	localparam int PREFIX_W = 4;
	localparam int SEL_LSB = 1;
	localparam int DIR_BIT = 0;
	localparam logic [PREFIX_W-1:0] MEM_PREFIX = 4'hA;
	localparam logic [PREFIX_W-1:0] PROT_PREFIX = 4'h6;
	localparam logic DIR_READ = 1'h1;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// Soft-protected region is the lower half of the array
	localparam logic [ADDR_W-1:0] PROT_TOP_ADDR = 8'h7F;
	localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;

	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} sep_state_t;
	typedef enum logic [1:0] {K_SLAVE, K_WADDR, K_DATA} sep_kind_t;

	// Prefix and strap compare of a slave address byte
	function automatic logic sep_addr_match(input logic [DATA_W-1:0] b,
		input logic [PREFIX_W-1:0] prefix, input logic [SEL_W-1:0] sel);
		sep_addr_match = (b[DATA_W-1 -: PREFIX_W] == prefix) && (b[SEL_LSB +: SEL_W] == sel);
	endfunction : sep_addr_match

endpackage : sep_pkg

// File: design/sep_fifo.sv
// Purpose: small valid/ready FIFO between byte receiver and page buffer
// Assumes: DEPTH is a power of two
// Notes: output data is read straight from storage at the read index
`timescale 1ns/1ps
`default_nettype none
module sep_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wptr;
		logic [PW-1:0] rptr;
		logic [PW:0] count;
	} sep_fifo_t;

	sep_fifo_t fifo_reg;
	sep_fifo_t fifo_next;
	logic push;
	logic pop;

	// Honest flags from the occupancy count
	assign in_ready = (fifo_reg.count != (PW+1)'(DEPTH));
	assign out_valid = (fifo_reg.count != '0);
	assign out_data = fifo_reg.mem[fifo_reg.rptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer and count update
	always_comb
	begin
		fifo_next = fifo_reg;
		if (push)
		begin
			fifo_next.mem[fifo_reg.wptr] = in_data;
			fifo_next.wptr = fifo_reg.wptr + 1'h1;
		end
		if (pop)
			fifo_next.rptr = fifo_reg.rptr + 1'h1;
		if (push && !pop)
			fifo_next.count = fifo_reg.count + 1'h1;
		else if (pop && !push)
			fifo_next.count = fifo_reg.count - 1'h1;
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (rst)
			fifo_reg <= '0;
		else
			fifo_reg <= fifo_next;
	end

endmodule : sep_fifo
`default_nettype wire

// File: tb/sep_master_model.sv
// Purpose: behavioural two-wire bus master that faces the slave port
// Assumes: the bench resolves the open-drain data line with a pull-up
// Notes: pins change only by non-blocking assignment at core clock edges
`timescale 1ns/1ps
`default_nettype none
module sep_master_model #(
	parameter int HALF = 6
) (
	// Clock
	input wire logic core_clk,
	// Bus pins
	output logic scl,
	output logic sda_rel,
	input wire logic sda_line
);
	// Idle bus, both lines released
	initial
	begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end

	// One phase, kept above the slave's synchroniser latency
	task automatic wait_half();
		repeat (HALF) @(posedge core_clk);
	endtask : wait_half

	// Works from idle and as a repeated start
	task automatic start_cond();
		wait_half();
		sda_rel <= 1'b1;
		wait_half();
		scl <= 1'b1;
		wait_half();
		sda_rel <= 1'b0;
		wait_half();
		scl <= 1'b0;
	endtask : start_cond

	// Every operation is closed here
	task automatic stop_cond();
		wait_half();
		sda_rel <= 1'b0;
		wait_half();
		scl <= 1'b1;
		wait_half();
		sda_rel <= 1'b1;
		wait_half();
	endtask : stop_cond

	// Data moves only mid-low, so no false start or stop
	task automatic pulse(input logic b, output logic s);
		wait_half();
		sda_rel <= b;
		wait_half();
		scl <= 1'b1;
		wait_half();
		s = sda_line;
		scl <= 1'b0;
	endtask : pulse

	// Byte out MSB first, then the slave's acknowledge
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			pulse(d[i], s);
		pulse(1'b1, s);
		ack = !s;
	endtask : wr_byte

	// Byte in, then acknowledge only if more are wanted
	task automatic rd_byte(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			pulse(1'b1, d[i]);
		pulse(!more, s);
	endtask : rd_byte
endmodule : sep_master_model
`default_nettype wire

// File: tb/sep_slave_test.sv
// Purpose: self-checking bench of the serial memory slave port
// Assumes: shortened program cycle, pull-up on the data line
// Notes: expected array contents are kept in exp_mem by the bench
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module sep_slave_test;
	import sep_pkg::*;
	localparam int PROG = 300;
	// Power-up to write delay of one millisecond in core clocks
	localparam int POWERUP_TO_WRITE_DELAY = 1000 * CLK_FREQ_MHZ;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [SEL_W-1:0] straps = '0;
	logic wp = 1'b0;
	wire logic scl;
	wire logic sda_rel;
	wire logic sda_o;
	wire logic sda_oe_n;
	wire logic prog_busy;
	wire logic prot_locked;
	// Wired-AND of both drivers, pull-up when released
	wire logic sda_line = sda_rel & (sda_oe_n | sda_o);
	int err_total = 0;
	int samples_checked = 0;
	logic [31:0] rng = 32'd77;
	logic [7:0] exp_mem [256];
	logic ack;
	logic [7:0] rd;
	logic [7:0] base;
	logic lock_exp = 1'b0;
	int busy_run = 0;
	int last_run = 0;

	always #10 core_clk = ~core_clk;

	sep_slave #(.PROG_CYCLES(PROG), .FIFO_DEPTH(FIFO_DEPTH)) u_dut (
		.core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
		.sda_o(sda_o), .sda_oe_n(sda_oe_n), .device_select_inputs(straps),
		.write_protect_in(wp), .prog_busy(prog_busy), .prot_locked(prot_locked));
	sep_master_model #(.HALF(6)) u_mst (.core_clk(core_clk), .scl(scl),
		.sda_rel(sda_rel), .sda_line(sda_line));

	// Pulling low is the only drive allowed
	always @(negedge core_clk)
		if (sda_oe_n === 1'b0) `CHK("sda_o", 1'b0, sda_o)

	// Length of each program cycle, counted where the flag has settled
	always @(negedge core_clk)
		if (prog_busy === 1'b1)
			busy_run <= busy_run + 1;
		else if (busy_run != 0)
		begin
			last_run <= busy_run;
			busy_run <= 0;
		end

	function automatic logic [7:0] rnd8();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[7:0];
	endfunction : rnd8

	// Only the low nibble advances inside a page
	function automatic logic [7:0] page_addr(input logic [7:0] b, input int i);
		return {b[7:4], b[3:0] + 4'(i)};
	endfunction : page_addr

	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	task automatic addr_phase(input logic [3:0] pfx, input logic [2:0] sel, input logic rdir,
		input logic exp_ack);
		u_mst.start_cond();
		u_mst.wr_byte({pfx, sel, rdir}, ack);
		`CHK("addr_ack", exp_ack, ack)
	endtask : addr_phase

	task automatic write_seq(input logic [7:0] b, input int n);
		logic [7:0] d;
		addr_phase(MEM_PREFIX, straps, 1'b0, 1'b1);
		u_mst.wr_byte(b, ack);
		`CHK("ptr_ack", 1'b1, ack)
		for (int i = 0; i < n; i++)
		begin
			d = rnd8();
			u_mst.wr_byte(d, ack);
			`CHK("data_ack", 1'b1, ack)
			if (!wp && !(lock_exp && (page_addr(b, i) <= PROT_TOP_ADDR)))
				exp_mem[page_addr(b, i)] = d;
		end
		u_mst.stop_cond();
	endtask : write_seq

	task automatic read_check(input logic [7:0] b, input int n);
		addr_phase(MEM_PREFIX, straps, 1'b0, 1'b1);
		u_mst.wr_byte(b, ack);
		addr_phase(MEM_PREFIX, straps, DIR_READ, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			u_mst.rd_byte(i < n - 1, rd);
			`CHK("read_data", exp_mem[8'(b + i)], rd)
		end
		u_mst.stop_cond();
	endtask : read_check

	// Bounded wait over one program cycle, bus must stay released
	task automatic wait_prog(input logic chk_len);
		int n;
		n = 0;
		while (prog_busy !== 1'b1 && n < 50)
		begin
			@(negedge core_clk);
			n++;
		end
		`CHK("busy_rise", 1'b1, prog_busy)
		if (prog_busy !== 1'b1)
			final_report();
		n = 0;
		while (prog_busy === 1'b1 && n < 1000)
		begin
			`CHK("sda_released", 1'b1, sda_oe_n)
			@(negedge core_clk);
			n++;
		end
		// The busy flag rises before the stop task returns, so use the counter
		@(negedge core_clk);
		if (chk_len)
			`CHK("prog_len", PROG, last_run)
		if (n >= 1000)
		begin
			err_total++;
			final_report();
		end
	endtask : wait_prog

	initial
	begin
		foreach (exp_mem[k])
			exp_mem[k] = ERASED_BYTE;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		straps <= 3'(rnd8());
		repeat (POWERUP_TO_WRITE_DELAY) @(posedge core_clk);
		// Each strap value, only the own one answers
		for (int s = 0; s < 8; s++)
		begin
			addr_phase(MEM_PREFIX, 3'(s), 1'b0, 3'(s) == straps);
			u_mst.stop_cond();
		end
		addr_phase(4'hB, straps, 1'b0, 1'b0);
		u_mst.wr_byte({MEM_PREFIX, straps, 1'b0}, ack);
		`CHK("no_start_ack", 1'b0, ack)
		u_mst.stop_cond();
		// Byte write, exact program length, read back
		base = rnd8();
		write_seq(base, 1);
		wait_prog(1'b1);
		read_check(base, 1);
		// Page write of 18 bytes wraps inside the page
		base = {1'b1, 3'(rnd8()), 4'hD};
		write_seq(base, 18);
		addr_phase(MEM_PREFIX, straps, 1'b0, 1'b0);
		u_mst.stop_cond();
		wait_prog(1'b0);
		addr_phase(MEM_PREFIX, straps, 1'b0, 1'b1);
		u_mst.stop_cond();
		repeat (20) @(posedge core_clk);
		`CHK("no_prog_wo_data", 1'b0, prog_busy)
		read_check({base[7:4], 4'h0}, 16);
		// Protect pin high, bytes acked but array kept
		wp <= 1'b1;
		write_seq(base, 2);
		wait_prog(1'b1);
		@(posedge core_clk);
		wp <= 1'b0;
		read_check(base, 2);
		// Protect register: read refused, one write, then silent
		addr_phase(PROT_PREFIX, straps, DIR_READ, 1'b0);
		u_mst.stop_cond();
		addr_phase(PROT_PREFIX, straps, 1'b0, 1'b1);
		u_mst.wr_byte(rnd8(), ack);
		u_mst.wr_byte(rnd8(), ack);
		`CHK("prot_ack", 1'b1, ack)
		u_mst.stop_cond();
		wait_prog(1'b0);
		`CHK("locked", 1'b1, prot_locked)
		addr_phase(PROT_PREFIX, straps, 1'b0, 1'b0);
		u_mst.stop_cond();
		// Lower half now refuses writes, bytes still acknowledged
		lock_exp = 1'b1;
		base = {1'b0, 3'(rnd8()), 4'h8};
		write_seq(base, 2);
		wait_prog(1'b1);
		read_check(base, 2);
		final_report();
	end
endmodule : sep_slave_test
`default_nettype wire
